// *** rtl/window_compare_consts.vh ***
/*
 Register offsets, field positions, widths and reset values for the window
 comparator configuration bank. Assumes inclusion by its bare name.
*/
`ifndef WINDOW_COMPARE_CONSTS_VH
`define WINDOW_COMPARE_CONSTS_VH

`define ADDR_W 8
`define DATA_W 8
`define LIMIT_W 12
`define HYST_W 6

`define OFF_CHANNEL_ALERT_ENABLE 8'h34
`define OFF_COMPARATOR_BLOCK_ENABLE 8'h37
`define OFF_CH0_HIGH_LIMIT_LOW_BYTE 8'h38
`define OFF_CH0_HIGH_LIMIT_UPPER_NIBBLE 8'h39
`define OFF_CH0_LOW_LIMIT_LOW_BYTE 8'h3a
`define OFF_CH0_LOW_LIMIT_UPPER_NIBBLE 8'h3b
`define OFF_CH1_HIGH_LIMIT_LOW_BYTE 8'h3c
`define OFF_CH1_HIGH_LIMIT_UPPER_NIBBLE 8'h3d
`define OFF_CH1_LOW_LIMIT_LOW_BYTE 8'h3e
`define OFF_CH1_LOW_LIMIT_UPPER_NIBBLE 8'h3f
`define OFF_CH0_HYSTERESIS 8'h40
`define OFF_CH1_HYSTERESIS 8'h41

`define LIMIT_STRIDE 4
`define HYST_STRIDE 1

`define RST_BYTE 8'h00
`define RST_NIBBLE 4'h0
`define RST_HYST 6'h00
`define RST_ALLOW 2'h0
`define RST_ON 1'h0

`define NIBBLE_PAD 4'h0
`define HYST_PAD 2'h0
`define ALLOW_PAD 6'h00
`define ON_PAD 7'h00

`endif

// *** rtl/window_compare_config_regs.v ***
/*
 Configuration register bank of a two-channel digital window comparator:
 global enable, per-channel alert allow bits, 12-bit high and low limits and
 6-bit hysteresis per channel, behind a plain strobe register port.
 Assumes the bus master is on core_clk and issues one-cycle strobes.
*/
`include "window_compare_consts.vh"

module window_compare_config_regs (
   // Clock, reset, enable
   input wire core_clk,
   input wire rst,
   input wire clkEn,
   // Register port
   input wire [`ADDR_W-1:0] regAddr,
   input wire [`DATA_W-1:0] regWrData,
   input wire regWrStb,
   input wire regRdStb,
   output reg [`DATA_W-1:0] regRdData,
   // Configuration to the comparator
   output reg windowCompareOn,
   output wire [1:0] alertAllow,
   output wire [2*`LIMIT_W-1:0] upperLimit,
   output wire [2*`LIMIT_W-1:0] lowerLimit,
   output wire [2*`HYST_W-1:0] hysteresisValue
);

   reg [1:0] alertAllowReg;
   reg [`DATA_W-1:0] upperBottom [0:1];
   reg [3:0] upperTop [0:1];
   reg [`DATA_W-1:0] lowerBottom [0:1];
   reg [3:0] lowerTop [0:1];
   reg [`HYST_W-1:0] hyst [0:1];
   reg [`DATA_W-1:0] next_rdData;

   // Per-channel allow is gated so a disabled block raises nothing
   assign alertAllow = alertAllowReg & {2{windowCompareOn}};

   always @(posedge core_clk) begin
      if (rst) begin
         windowCompareOn <= `RST_ON;
         alertAllowReg <= `RST_ALLOW;
      end else if (clkEn && regWrStb) begin
         if (regAddr == `OFF_COMPARATOR_BLOCK_ENABLE)
            windowCompareOn <= regWrData[0];
         if (regAddr == `OFF_CHANNEL_ALERT_ENABLE)
            alertAllowReg <= regWrData[1:0];
      end
   end

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1) begin : chanRegs
         // Channel stride: low byte, top nibble, low limit pair = 4 offsets
         localparam integer HI_LO = `OFF_CH0_HIGH_LIMIT_LOW_BYTE + ch * `LIMIT_STRIDE;
         localparam integer HI_UP = `OFF_CH0_HIGH_LIMIT_UPPER_NIBBLE + ch * `LIMIT_STRIDE;
         localparam integer LO_LO = `OFF_CH0_LOW_LIMIT_LOW_BYTE + ch * `LIMIT_STRIDE;
         localparam integer LO_UP = `OFF_CH0_LOW_LIMIT_UPPER_NIBBLE + ch * `LIMIT_STRIDE;
         localparam integer HY_A = `OFF_CH0_HYSTERESIS + ch * `HYST_STRIDE;
         // Offsets fit the address width, so the cut drops only zeros
         wire [`ADDR_W-1:0] hiLo = HI_LO[`ADDR_W-1:0];
         wire [`ADDR_W-1:0] hiUp = HI_UP[`ADDR_W-1:0];
         wire [`ADDR_W-1:0] loLo = LO_LO[`ADDR_W-1:0];
         wire [`ADDR_W-1:0] loUp = LO_UP[`ADDR_W-1:0];
         wire [`ADDR_W-1:0] hyA = HY_A[`ADDR_W-1:0];
         always @(posedge core_clk) begin
            if (rst) begin
               upperBottom[ch] <= `RST_BYTE;
               upperTop[ch] <= `RST_NIBBLE;
               lowerBottom[ch] <= `RST_BYTE;
               lowerTop[ch] <= `RST_NIBBLE;
               hyst[ch] <= `RST_HYST;
            end else if (clkEn && regWrStb) begin
               if (regAddr == hiLo)
                  upperBottom[ch] <= regWrData;
               if (regAddr == hiUp)
                  upperTop[ch] <= regWrData[3:0];
               if (regAddr == loLo)
                  lowerBottom[ch] <= regWrData;
               if (regAddr == loUp)
                  lowerTop[ch] <= regWrData[3:0];
               if (regAddr == hyA)
                  hyst[ch] <= regWrData[`HYST_W-1:0];
            end
         end
         assign upperLimit[ch*`LIMIT_W +: `LIMIT_W] = {upperTop[ch], upperBottom[ch]};
         assign lowerLimit[ch*`LIMIT_W +: `LIMIT_W] = {lowerTop[ch], lowerBottom[ch]};
         // One hysteresis serves both comparators of the channel
         assign hysteresisValue[ch*`HYST_W +: `HYST_W] = hyst[ch];
      end
   endgenerate

   // Unmapped offsets read zero; unused upper bits pad with zero
   always @* begin
      case (regAddr)
         `OFF_COMPARATOR_BLOCK_ENABLE: next_rdData = {`ON_PAD, windowCompareOn};
         `OFF_CHANNEL_ALERT_ENABLE: next_rdData = {`ALLOW_PAD, alertAllowReg};
         `OFF_CH0_HIGH_LIMIT_LOW_BYTE: next_rdData = upperBottom[0];
         `OFF_CH0_HIGH_LIMIT_UPPER_NIBBLE: next_rdData = {`NIBBLE_PAD, upperTop[0]};
         `OFF_CH0_LOW_LIMIT_LOW_BYTE: next_rdData = lowerBottom[0];
         `OFF_CH0_LOW_LIMIT_UPPER_NIBBLE: next_rdData = {`NIBBLE_PAD, lowerTop[0]};
         `OFF_CH1_HIGH_LIMIT_LOW_BYTE: next_rdData = upperBottom[1];
         `OFF_CH1_HIGH_LIMIT_UPPER_NIBBLE: next_rdData = {`NIBBLE_PAD, upperTop[1]};
         `OFF_CH1_LOW_LIMIT_LOW_BYTE: next_rdData = lowerBottom[1];
         `OFF_CH1_LOW_LIMIT_UPPER_NIBBLE: next_rdData = {`NIBBLE_PAD, lowerTop[1]};
         `OFF_CH0_HYSTERESIS: next_rdData = {`HYST_PAD, hyst[0]};
         `OFF_CH1_HYSTERESIS: next_rdData = {`HYST_PAD, hyst[1]};
         default: next_rdData = `RST_BYTE;
      endcase
   end

   // Read data stands from the cycle after the strobe until the next edge with clkEn high
   always @(posedge core_clk) begin
      if (rst)
         regRdData <= `RST_BYTE;
      else if (clkEn)
         regRdData <= regRdStb ? next_rdData : `RST_BYTE;
   end

endmodule // window_compare_config_regs

// *** tb/window_compare_config_regs_assertions.sv ***
/* Checker for the window comparator register bank.
   Bound to the bank; sees only its ports. */
module window_compare_config_regs_checker (
   // Clock, reset, register port
   input logic core_clk, rst, clkEn, regWrStb, regRdStb,
   input logic [7:0] regAddr, regWrData, regRdData,
   // Configuration outputs
   input logic windowCompareOn,
   input logic [1:0] alertAllow,
   input logic [23:0] upperLimit, lowerLimit,
   input logic [11:0] hysteresisValue
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire wr = regWrStb & clkEn;
   a_on_write: assert property (
      wr && regAddr == 8'h37 |=> windowCompareOn == $past(regWrData[0])) else $error("on");
   a_allow_gate: assert property (
      !windowCompareOn |-> alertAllow == 2'h0) else $error("gate");
   a_hi0_low: assert property (
      wr && regAddr == 8'h38 |=> upperLimit[7:0] == $past(regWrData)) else $error("38");
   a_lo0_top: assert property (
      wr && regAddr == 8'h3b |=> lowerLimit[11:8] == $past(regWrData[3:0])) else $error("3b");
   a_hi1_top: assert property (
      wr && regAddr == 8'h3d |=> upperLimit[23:20] == $past(regWrData[3:0])) else $error("3d");
   a_lo1_low: assert property (
      wr && regAddr == 8'h3e |=> lowerLimit[19:12] == $past(regWrData)) else $error("3e");
   a_hys0_set: assert property (
      wr && regAddr == 8'h40 |=> hysteresisValue[5:0] == $past(regWrData[5:0])) else $error("40");
   a_hys1_set: assert property (
      wr && regAddr == 8'h41 |=> hysteresisValue[11:6] == $past(regWrData[5:0])) else $error("41");
endmodule // window_compare_config_regs_checker

bind window_compare_config_regs window_compare_config_regs_checker chk (.*);

// *** tb/window_compare_config_regs_tb_top.sv ***
/* Self-checking bench for the register bank.
   Drives the strobe port itself; clkEn is held high except for one cycle that checks an ignored write. */
module window_compare_config_regs_tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 0, rst = 1, clkEn = 1, regWrStb = 0, regRdStb = 0;
   logic [7:0] regAddr = 8'h00, regWrData = 8'h00;
   wire [7:0] regRdData;
   wire windowCompareOn;
   wire [1:0] alertAllow;
   wire [23:0] upperLimit, lowerLimit;
   wire [11:0] hysteresisValue;
   int badCount = 0, totalChecks = 0;
   window_compare_config_regs uut (.*);
   initial forever #20 core_clk = ~core_clk;
   // Byte written to each place is its address inverted
   function automatic logic [7:0] rv(input logic [7:0] a, input logic w);
      case (a)
         8'h34: return w ? 8'h03 : 8'h00;
         8'h37, 8'h3f: return 8'h00;
         8'h39, 8'h3b, 8'h3d, 8'h40, 8'h41: return w ? (~a & 8'h3f) : 8'h00;
         8'h38, 8'h3a, 8'h3c, 8'h3e: return w ? ~a : 8'h00;
         default: return 8'h00;
      endcase
   endfunction
   task automatic cmp(input logic [23:0] got, exp);
      totalChecks++;
      if (got !== exp) begin
         badCount++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, d);
      @(posedge core_clk) {regWrStb, regAddr, regWrData} <= {1'b1, a, d};
      @(posedge core_clk) regWrStb <= 1'b0;
      #1;
   endtask
   task automatic sweep(input logic w);
      for (int a = 8'h34; a <= 8'h41; a++) begin
         @(posedge core_clk) {regRdStb, regAddr} <= {1'b1, 8'(a)};
         @(posedge core_clk) regRdStb <= 1'b0;
         #1 cmp(regRdData, rv(8'(a), w));
      end
   endtask
   task automatic wrapUp;
      if (badCount == 0 && totalChecks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      sweep(0);
      for (int a = 8'h34; a <= 8'h41; a++) wr(8'(a), ~8'(a));
      sweep(1);
      cmp(upperLimit, 24'h2c36c7);
      cmp(lowerLimit, 24'h0c14c5);
      cmp(hysteresisValue, 12'hfbf);
      cmp(alertAllow, 2'h0);
      wr(8'h37, 8'h01);
      cmp({windowCompareOn, alertAllow}, 3'h7);
      wr(8'h34, 8'h02);
      cmp(alertAllow, 2'h2);
      @(posedge core_clk) rst <= 1'b1;
      @(posedge core_clk) rst <= 1'b0;
      sweep(0);
      // A write while the clock enable is low must be ignored
      @(posedge core_clk) {clkEn, regWrStb, regAddr, regWrData} <= {1'b0, 1'b1, 8'h40, 8'h15};
      @(posedge core_clk) {clkEn, regWrStb} <= {1'b1, 1'b0};
      #1 cmp(hysteresisValue, 12'h000);
      wrapUp;
   end
   initial begin
      #20000;
      badCount++;
      wrapUp;
   end
endmodule // window_compare_config_regs_tb_top
